// File: rtl/tone_code_receiver.v
// decode, steering and latched output side of a dual tone code receiver
`timescale 1ns/1ps
`include "tone_code_defines.vh"

module tone_code_receiver #(
   parameter STEER_DELAY = `STEER_DELAY_DEF,
   parameter ABSENT_CYC  = (`ABSENT_MIN_US + `ABSENT_MAX_US) / 2 * (`CLK_HZ / 1000000)
) (
   input  wire       mclk_in,
   input  wire       rst_in,
   input  wire       tone_valid_in,
   input  wire [3:0] tone_pair_in,
   input  wire       table_select_in,
   input  wire       power_down_in,
   input  wire       code_output_enable_in,
   input  wire       steering_guard_pin_in,
   output reg        steering_guard_pin_out,
   output reg        steering_guard_pin_oe_out,
   output reg        early_tone_flag_out,
   output reg        code_ready_flag_out,
   output reg  [3:0] code_out,
   output reg  [3:0] code_oe_out,
   output reg        steer_above_out
);

   // every timing count is a number of device clock cycles
   // setup count: data ahead of ready flag, rounded up to whole cycles
   localparam SETUP_CYC = (`SETUP_NS * (`CLK_HZ / 1000000) + 999) / 1000;
   localparam ABS_MIN_CYC = `ABSENT_MIN_US * (`CLK_HZ / 1000000);

   // **************************************************
   // input synchronisers
   // **************************************************
   reg [4:0] sync1_reg;
   reg [4:0] sync2_reg;
   reg [3:0] pair_s1_reg;
   reg [3:0] pair_s2_reg;
   wire      valid_s = sync2_reg[0];
   wire      sel_s   = sync2_reg[1];
   wire      pdn_s   = sync2_reg[2];
   wire      oe_s    = sync2_reg[3];
   wire      steer_s = sync2_reg[4];

   // pair bits cross one by one: safe only because the pair is steady while valid is high
   // two-stage sampling
   always @(posedge mclk_in) begin
      if (rst_in) begin
         sync1_reg   <= 5'h00;
         sync2_reg   <= 5'h00;
         pair_s1_reg <= 4'h0;
         pair_s2_reg <= 4'h0;
      end else begin
         sync1_reg   <= {steering_guard_pin_in, code_output_enable_in, power_down_in,
                         table_select_in, tone_valid_in};
         sync2_reg   <= sync1_reg;
         pair_s1_reg <= tone_pair_in;
         pair_s2_reg <= pair_s1_reg;
      end
   end

   // **************************************************
   // code tables
   // **************************************************
   // sixteen distinct codes
   function [3:0] pair_code;
      input [3:0] pair;
      input       sel;
      reg   [3:0] num;
      begin
         num = {2'b00, pair[3:2]} * 4'h3 + {2'b00, pair[1:0]} + 4'h1;
         pair_code = num;
         // table selection for the odd keys
         if (pair[1:0] == `COL_1633)
            pair_code = sel ? (`CODE_A_HIGH + {2'b00, pair[3:2]})
                            : ((pair[3:2] == `ROW_941) ? `CODE_D_LOW
                                                       : (`CODE_A_LOW + {2'b00, pair[3:2]}));
         else if (pair[3:2] == `ROW_941) begin
            case (pair[1:0])
               `COL_1336: pair_code = sel ? `CODE_ZERO_HIGH : `CODE_ZERO_LOW;
               `COL_1209: pair_code = sel ? `CODE_STAR_HIGH : `CODE_STAR_LOW;
               default:   pair_code = sel ? `CODE_HASH_HIGH : `CODE_HASH_LOW;
            endcase
         end
      end
   endfunction

   // **************************************************
   // early flag with absence detection
   // **************************************************
   reg        present_reg;
   reg [31:0] absent_cnt_reg;
   reg [3:0]  held_pair_reg;

   // rise at once, fall on loss, absence counted from the clock
   always @(posedge mclk_in) begin
      if (rst_in || pdn_s) begin
         present_reg    <= 1'b0;
         absent_cnt_reg <= 32'h0;
         held_pair_reg  <= 4'h0;
      end else if (valid_s) begin
         present_reg    <= 1'b1;
         absent_cnt_reg <= 32'h0;
         held_pair_reg  <= pair_s2_reg;
      end else begin
         present_reg    <= 1'b0;
         if (absent_cnt_reg < ABSENT_CYC)
            absent_cnt_reg <= absent_cnt_reg + 32'h1;
      end
   end
   wire tone_gone = !valid_s && (absent_cnt_reg >= ABS_MIN_CYC);

   // **************************************************
   // steering state machine
   // **************************************************
   localparam ST_IDLE  = 4'h1;
   localparam ST_RAMP  = 4'h2;
   localparam ST_SETUP = 4'h4;
   localparam ST_HOLD  = 4'h8;

   reg [3:0]  state_reg;
   reg [31:0] cnt_reg;
   reg [3:0]  latch_reg;
   reg        ready_reg;
   reg        guard_drive_reg;

   // rc network modelled as a count; guard drive charges the node high
   always @(posedge mclk_in) begin
      if (rst_in || pdn_s) begin
         state_reg       <= ST_IDLE;
         cnt_reg         <= 32'h0;
         latch_reg       <= 4'h0;
         ready_reg       <= 1'b0;
         guard_drive_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               cnt_reg <= 32'h0;
               if (present_reg)
                  state_reg <= ST_RAMP;
            end
            ST_RAMP: begin
               if (!present_reg) begin
                  state_reg <= ST_IDLE;
               end else if (steer_s || cnt_reg >= STEER_DELAY - 1) begin
                  // host-set table select picks the code table
                  latch_reg       <= pair_code(held_pair_reg, sel_s);
                  guard_drive_reg <= 1'b1;
                  cnt_reg         <= 32'h0;
                  state_reg       <= ST_SETUP;
               end else
                  cnt_reg <= cnt_reg + 32'h1;
            end
            ST_SETUP: begin
               cnt_reg <= cnt_reg + 32'h1;
               // guard lets go as soon as the early flag drops
               guard_drive_reg <= present_reg;
               if (cnt_reg >= SETUP_CYC - 1) begin
                  ready_reg <= 1'b1;
                  state_reg <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               // guard keeps driving while early flag stays high
               guard_drive_reg <= present_reg;
               if (tone_gone && !guard_drive_reg) begin
                  // ready clears once the tone is absent for the minimum absence count and the guard has let go; free for a new pair
                  ready_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // **************************************************
   // registered outputs
   // **************************************************
   // last code, enable gates the drivers even in power-down; early and ready flags, code and guard pin quiet in power-down
   always @(posedge mclk_in) begin
      if (rst_in) begin
         early_tone_flag_out       <= 1'b0;
         code_ready_flag_out       <= 1'b0;
         code_out                  <= 4'h0;
         code_oe_out               <= 4'h0;
         steering_guard_pin_out    <= 1'b0;
         steering_guard_pin_oe_out <= 1'b0;
         steer_above_out           <= 1'b0;
      end else begin
         early_tone_flag_out       <= present_reg && !pdn_s;
         code_ready_flag_out       <= ready_reg;
         code_out                  <= latch_reg;
         code_oe_out               <= {4{oe_s}};
         steering_guard_pin_out    <= guard_drive_reg || (state_reg == ST_RAMP);
         steering_guard_pin_oe_out <= !pdn_s;
         steer_above_out           <= steer_s;
      end
   end

endmodule

// File: rtl/tone_code_defines.vh
// constants for the tone code receiver: table codes, widths and timing counts
`ifndef TONE_CODE_DEFINES_VH
`define TONE_CODE_DEFINES_VH
`define CLK_HZ            50000000
`define CODE_W            4
`define PAIR_W            4
// tone pair index: low group row in bits 3:2, high group column in bits 1:0
`define ROW_697           2'h0
`define ROW_941           2'h3
`define COL_1209          2'h0
`define COL_1336          2'h1
`define COL_1477          2'h2
`define COL_1633          2'h3
// codes that differ between the two tables
`define CODE_ZERO_LOW     4'hA
`define CODE_ZERO_HIGH    4'h0
`define CODE_STAR_LOW     4'hB
`define CODE_STAR_HIGH    4'hA
`define CODE_HASH_LOW     4'hC
`define CODE_HASH_HIGH    4'hB
`define CODE_A_LOW        4'hD
`define CODE_A_HIGH       4'hC
`define CODE_D_LOW        4'h0
// tone absent detection window in microseconds
`define ABSENT_MIN_US     500
`define ABSENT_MAX_US     8500
// data valid ahead of the ready flag, in nanoseconds
`define SETUP_NS          3400
// default steering delay standing in for the external rc network
`define STEER_DELAY_DEF   2000000
`endif

// File: test/tone_code_receiver_properties.sv
// port-level assertions for the tone code receiver
`timescale 1ns/1ps
module tone_code_receiver_properties (
   input wire       mclk_in,
   input wire       rst_in,
   input wire       tone_valid_in,
   input wire       power_down_in,
   input wire       code_output_enable_in,
   input wire       steering_guard_pin_out,
   input wire       steering_guard_pin_oe_out,
   input wire       early_tone_flag_out,
   input wire       code_ready_flag_out,
   input wire [3:0] code_out,
   input wire [3:0] code_oe_out,
   input wire       steer_above_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // tones held long enough to pass the input synchronisers
   sequence tone_held; (tone_valid_in && !power_down_in)[*5]; endsequence
   sequence awake; (!power_down_in)[*4]; endsequence
   a_early_rises: assert property (tone_held |-> early_tone_flag_out)
      else $error("early flag low with tones held");
   a_early_falls: assert property ((!tone_valid_in)[*5] |-> !early_tone_flag_out)
      else $error("early flag high without tones");
   a_guard_drops: assert property ($fell(early_tone_flag_out) |-> ##[0:4] !steering_guard_pin_out)
      else $error("guard still high after early flag fell");
   a_guard_holds: assert property (awake ##0 (code_ready_flag_out && early_tone_flag_out
      && steering_guard_pin_out) |=> steering_guard_pin_out || !early_tone_flag_out)
      else $error("guard released while early flag high");
   a_setup_time: assert property ($rose(code_ready_flag_out) |-> $past(code_out, 160) == code_out)
      else $error("code not settled before ready flag");
   a_ready_holds: assert property (awake ##0 (code_ready_flag_out && steer_above_out)
      |=> code_ready_flag_out)
      else $error("ready flag fell with steering above threshold");
   a_code_frozen: assert property (code_ready_flag_out && $past(code_ready_flag_out) |-> $stable(code_out))
      else $error("latched code changed while ready");
   // enable passes two sync stages and the output stage: three cycles late
   a_bus_enables: assert property (!$past(rst_in, 3) && !$past(rst_in, 2) && !$past(rst_in)
      |-> code_oe_out == {4{$past(code_output_enable_in, 3)}})
      else $error("code drivers do not follow the enable");
endmodule
bind tone_code_receiver tone_code_receiver_properties i_props (
   .mclk_in                   (mclk_in),
   .rst_in                    (rst_in),
   .tone_valid_in             (tone_valid_in),
   .power_down_in             (power_down_in),
   .code_output_enable_in     (code_output_enable_in),
   .steering_guard_pin_out    (steering_guard_pin_out),
   .steering_guard_pin_oe_out (steering_guard_pin_oe_out),
   .early_tone_flag_out       (early_tone_flag_out),
   .code_ready_flag_out       (code_ready_flag_out),
   .code_out                  (code_out),
   .code_oe_out               (code_oe_out),
   .steer_above_out           (steer_above_out)
);

// File: test/host_model.sv
// host model that enables the code bus and samples it on the ready flag
`timescale 1ns/1ps
module host_model (
   input  wire       mclk_in,
   input  wire       want_in,
   input  wire       ready_in,
   input  wire [3:0] code_in,
   input  wire [3:0] code_oe_in,
   output reg        enable_out,
   output reg  [3:0] bus_out
);
   reg ready_d_reg = 1'b0;
   // a floating bus reads as the inverse of its last value, so it never repeats the previous code
   always @(posedge mclk_in) begin
      enable_out  <= want_in;
      ready_d_reg <= ready_in;
      if (ready_in && !ready_d_reg)
         bus_out <= (code_oe_in === 4'hF) ? code_in : ~bus_out;
   end
endmodule

// File: test/tb_top.sv
// self-checking testbench for the tone code receiver
`timescale 1ns/1ps
module tb_top;
   reg        mclk_in = 0, rst_in = 1, tone_valid_in = 0, table_select_in = 0;
   reg        power_down_in = 0, want = 1, node_reg = 0;
   reg  [3:0] tone_pair_in = 4'h0;
   reg  [7:0] ramp_reg = 8'h00;
   wire       gt_out, gt_oe, early, ready, en, steer;
   wire [3:0] code, code_oe, seen;
   integer    n_fail = 0, n_tests = 0, i, k, waited;
   always #10 mclk_in = ~mclk_in;
   // rc node: charges while the guard drives high, collapses when it lets go
   always @(posedge mclk_in) begin
      ramp_reg <= (gt_oe && gt_out) ? ramp_reg + {7'h00, ramp_reg < 8'h14} : 8'h00;
      node_reg <= (ramp_reg == 8'h14);
   end
   tone_code_receiver #(.STEER_DELAY(20), .ABSENT_CYC(26000)) i_dut (.mclk_in(mclk_in),
      .rst_in(rst_in), .tone_valid_in(tone_valid_in), .tone_pair_in(tone_pair_in),
      .table_select_in(table_select_in), .power_down_in(power_down_in),
      .code_output_enable_in(en), .steering_guard_pin_in(node_reg),
      .steering_guard_pin_out(gt_out), .steering_guard_pin_oe_out(gt_oe),
      .early_tone_flag_out(early), .code_ready_flag_out(ready), .code_out(code),
      .code_oe_out(code_oe), .steer_above_out(steer));
   host_model i_host (.mclk_in(mclk_in), .want_in(want), .ready_in(ready), .code_in(code),
      .code_oe_in(code_oe), .enable_out(en), .bus_out(seen));
   task check(input [63:0] what, input [3:0] got, input [3:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // bounded wait for the ready flag, sampled mid-cycle
   task wait_ready(input lvl, input integer lim);
      begin
         waited = 0;
         while (ready !== lvl && waited < lim) begin @(negedge mclk_in); waited = waited + 1; end
         if (waited >= lim) begin
            check("wait", {3'h0, ready}, {3'h0, lvl});
            give_verdict;
         end
      end
   endtask
   // expected code: digits count up, star, zero, hash and the fourth column differ by table
   function [3:0] exp_code(input [3:0] p, input s);
      begin
         if (p[1:0] == 2'h3) exp_code = 4'hD + p[3:2] - s;
         else if (p[3:2] != 2'h3) exp_code = p[3:2] * 3 + p[1:0] + 1;
         else if (p[1:0] == 2'h1) exp_code = s ? 4'h0 : 4'hA;
         else exp_code = (p[1:0] == 2'h0 ? 4'hB : 4'hC) - s;
      end
   endfunction
   task send(input [3:0] p, input s);
      begin
         @(posedge mclk_in);
         tone_pair_in <= p;
         table_select_in <= s;
         tone_valid_in <= 1'b1;
         wait_ready(1'b1, 1000);
         @(negedge mclk_in);
         check("code", code, exp_code(p, s));
         check("hostbus", seen, exp_code(p, s));
         check("guard", {2'h0, gt_oe, gt_out}, 4'h3);
         check("steer", {3'h0, steer}, 4'h1);
         @(posedge mclk_in);
         tone_valid_in <= 1'b0;
         repeat (6) @(negedge mclk_in);
         check("early", {3'h0, early}, 4'h0);
         check("ready", {3'h0, ready}, 4'h1);
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk_in);
      rst_in <= 1'b0;
      for (k = 0; k < 2; k = k + 1)
         for (i = 0; i < 16; i = i + 1) begin
            send(i[3:0], k[0]);
            // power-down clears the latch so the next pair needs no long pause
            @(posedge mclk_in) power_down_in <= 1'b1;
            repeat (6) @(posedge mclk_in);
            power_down_in <= 1'b0;
            check("pdready", {3'h0, ready}, 4'h0);
            repeat (6) @(posedge mclk_in);
         end
      send(4'h5, 1'b0);
      // a pair while ready is high is refused
      @(posedge mclk_in) tone_valid_in <= 1'b1;
      tone_pair_in <= 4'h6;
      repeat (100) @(posedge mclk_in);
      tone_valid_in <= 1'b0;
      check("refused", code, 4'h5);
      wait_ready(1'b0, 40000);
      check("absence", {3'h0, waited >= 24900}, 4'h1);
      send(4'h9, 1'b1);
      @(posedge mclk_in) want <= 1'b0;
      repeat (8) @(negedge mclk_in);
      check("float", code_oe, 4'h0);
      give_verdict;
   end
endmodule
